// File: hw/adc_seq_regs.svh
// Field positions and phase timing constants of the conversion sequencer.
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
`define CTRL_WIDTH 16
`define CTRL_CTC_MSB 15
`define CTRL_CTC_LSB 14
`define CTRL_STC_MSB 13
`define CTRL_STC_LSB 12
`define CTRL_PWROFF_BIT 7
`define CTC_FAST 2'h0
`define CTC_RESERVED 2'h1
`define CTC_SLOW 2'h2
`define CTC_MEDIUM 2'h3
`define HALVES_PER_CLK 2
`define RESULT_BITS 10
`define RESULT_ZERO 10'h000
`define RESULT_FULL 10'h3ff
`define RESULT_MSB_MASK 10'h200
`define SAMPLE_HALVES_S0 120
`define SAMPLE_HALVES_S1 140
`define SAMPLE_HALVES_S2 200
`define SAMPLE_HALVES_S3 400
`define COMP_HALVES_S0 240
`define COMP_HALVES_SX 280
`define SCALE_FAST 1
`define SCALE_MEDIUM 2
`define SCALE_SLOW 4
`define EXTRA_HALVES_F0 28
`define EXTRA_HALVES_F1 16
`define EXTRA_HALVES_F2 52
`define EXTRA_HALVES_F3 44
`define EXTRA_HALVES_M0 52
`define EXTRA_HALVES_M1 28
`define EXTRA_HALVES_M2 100
`define EXTRA_HALVES_M3 52
`define EXTRA_HALVES_S0 100
`define EXTRA_HALVES_S1 52
`define EXTRA_HALVES_S2 196
`define EXTRA_HALVES_S3 164
`define TOTAL_MIN_HALVES 388
`endif

// File: hw/adc_seq_pkg.sv
// Types shared by the conversion sequencer modules.
package adc_seq_pkg;
  typedef logic [1:0] sel_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_COMPARE, ST_EXTRA}
    seq_state_t;
  typedef enum logic [1:0] {PH_SAMPLE, PH_COMPARE, PH_EXTRA} phase_t;
endpackage : adc_seq_pkg

// File: hw/sar_link_if.sv
// Link between the phase sequencer and the approximation register.
interface sar_link_if #(parameter int RES_W = 10);
  logic load;
  logic decide;
  logic cmp_above;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] code;
  modport seq (output load, output decide, output cmp_above,
    input trial, input code);
  modport sar (input load, input decide, input cmp_above,
    output trial, output code);
endinterface : sar_link_if

// File: hw/sar_register.sv
// Successive approximation register that settles one bit per decision.
`include "adc_seq_regs.svh"
module sar_register import adc_seq_pkg::*; #(
  parameter int RES_W = `RESULT_BITS
) (
  input wire logic clock,
  input wire logic srst,
  sar_link_if.sar link
);
  logic [RES_W-1:0] code_ff;
  logic [RES_W-1:0] mask_ff;

  assign link.trial = code_ff | mask_ff;
  assign link.code = code_ff;

  // One comparison step keeps or drops the bit under trial.
  always_ff @(posedge clock) begin
    if (srst) begin
      code_ff <= '0;
      mask_ff <= '0;
    end else if (link.load) begin
      code_ff <= '0;
      mask_ff <= RES_W'(`RESULT_MSB_MASK);
    end else if (link.decide) begin
      if (link.cmp_above) begin
        code_ff <= code_ff | mask_ff;
      end
      mask_ff <= mask_ff >> 1;
    end
  end

  mask_walk_a: assert property (@(posedge clock) disable iff (srst)
    link.decide && !link.load |=> mask_ff == ($past(mask_ff) >> 1))
    else $error("Trial bit did not move one place down.");
endmodule : sar_register

// File: hw/adc_conversion_timing_sequencer.sv
// Phase sequencer for a 10-bit successive approximation conversion.
`include "adc_seq_regs.svh"
module adc_conversion_timing_sequencer import adc_seq_pkg::*; #(
  parameter int CNT_W = 11,
  parameter int RES_W = `RESULT_BITS
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic conv_start,
  input wire logic [`CTRL_WIDTH-1:0] converter_control_register,
  input wire logic cmp_above,
  input wire logic input_below_ground,
  input wire logic input_above_ref,
  output logic analog_enable,
  output logic sample_switch,
  output logic [RES_W-1:0] dac_code,
  output logic busy,
  output logic [RES_W-1:0] result,
  output logic result_valid,
  output logic ctrl_reserved_error
);
  sar_link_if #(.RES_W(RES_W)) link ();

  seq_state_t st_ff;
  sel_t ctc_ff;
  sel_t stc_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [3:0] bit_ff;
  logic below_ff;
  logic above_ff;
  logic [RES_W-1:0] result_ff;
  logic valid_ff;
  logic reserved_ff;
  logic analog_on_ff;
  sel_t ctc_in;
  sel_t stc_in;
  logic pwr_off;
  logic accept;
  logic phase_end;

  function automatic logic [11:0] phase_halves(input sel_t ctc,
      input sel_t stc, input phase_t ph);
    logic [11:0] base;
    logic [11:0] scale;
    base = '0;
    scale = 12'(`SCALE_FAST);
    unique case (ctc)
      `CTC_MEDIUM: scale = 12'(`SCALE_MEDIUM);
      `CTC_SLOW: scale = 12'(`SCALE_SLOW);
      default: scale = 12'(`SCALE_FAST);
    endcase
    unique case (ph)
      PH_SAMPLE: begin
        unique case (stc)
          2'h0: base = 12'(`SAMPLE_HALVES_S0);
          2'h1: base = 12'(`SAMPLE_HALVES_S1);
          2'h2: base = 12'(`SAMPLE_HALVES_S2);
          2'h3: base = 12'(`SAMPLE_HALVES_S3);
        endcase
        base = 12'(base * scale);
      end
      PH_COMPARE: begin
        base = (stc == 2'h0) ? 12'(`COMP_HALVES_S0) : 12'(`COMP_HALVES_SX);
        base = 12'(base * scale);
      end
      default: begin
        unique case ({ctc, stc})
          4'h0: base = 12'(`EXTRA_HALVES_F0);
          4'h1: base = 12'(`EXTRA_HALVES_F1);
          4'h2: base = 12'(`EXTRA_HALVES_F2);
          4'h3: base = 12'(`EXTRA_HALVES_F3);
          4'hc: base = 12'(`EXTRA_HALVES_M0);
          4'hd: base = 12'(`EXTRA_HALVES_M1);
          4'he: base = 12'(`EXTRA_HALVES_M2);
          4'hf: base = 12'(`EXTRA_HALVES_M3);
          4'h8: base = 12'(`EXTRA_HALVES_S0);
          4'h9: base = 12'(`EXTRA_HALVES_S1);
          4'ha: base = 12'(`EXTRA_HALVES_S2);
          4'hb: base = 12'(`EXTRA_HALVES_S3);
          default: base = 12'(`EXTRA_HALVES_F0);
        endcase
      end
    endcase
    return base;
  endfunction : phase_halves

  // Half-period units become whole clock cycles.
  function automatic logic [CNT_W-1:0] phase_cyc(input sel_t ctc,
      input sel_t stc, input phase_t ph);
    logic [11:0] halves;
    halves = phase_halves(ctc, stc, ph);
    return CNT_W'(halves / 12'(`HALVES_PER_CLK));
  endfunction : phase_cyc

  function automatic logic [CNT_W-1:0] step_cyc(input sel_t ctc,
      input sel_t stc);
    logic [CNT_W-1:0] comp;
    comp = phase_cyc(ctc, stc, PH_COMPARE);
    return CNT_W'(comp / CNT_W'(RES_W));
  endfunction : step_cyc

  assign ctc_in = converter_control_register[`CTRL_CTC_MSB:`CTRL_CTC_LSB];
  assign stc_in = converter_control_register[`CTRL_STC_MSB:`CTRL_STC_LSB];
  assign pwr_off = converter_control_register[`CTRL_PWROFF_BIT];
  assign accept = (st_ff == ST_IDLE) && conv_start && !pwr_off
    && (ctc_in != `CTC_RESERVED);
  assign phase_end = (st_ff != ST_IDLE) && (cnt_ff == '0)
    && ((st_ff != ST_COMPARE) || (bit_ff == 4'h0));

  assign link.load = accept;
  assign link.decide = (st_ff == ST_COMPARE) && (cnt_ff == '0) && !pwr_off;
  assign link.cmp_above = cmp_above;
  assign dac_code = link.trial;
  assign sample_switch = (st_ff == ST_SAMPLE);
  assign busy = (st_ff != ST_IDLE);
  assign analog_enable = analog_on_ff;
  assign result = result_ff;
  assign result_valid = valid_ff;
  assign ctrl_reserved_error = reserved_ff;

  // Phase sequence and per-phase countdown.
  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
      bit_ff <= 4'h0;
      ctc_ff <= `CTC_FAST;
      stc_ff <= 2'h0;
    end else if (pwr_off) begin
      st_ff <= ST_IDLE;
      cnt_ff <= '0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          if (accept) begin
            ctc_ff <= ctc_in;
            stc_ff <= stc_in;
            st_ff <= ST_SAMPLE;
            cnt_ff <= phase_cyc(ctc_in, stc_in, PH_SAMPLE) - 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (cnt_ff == '0) begin
            st_ff <= ST_COMPARE;
            bit_ff <= 4'(RES_W - 1);
            cnt_ff <= step_cyc(ctc_ff, stc_ff) - 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        ST_COMPARE: begin
          if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end else if (bit_ff == 4'h0) begin
            st_ff <= ST_EXTRA;
            cnt_ff <= phase_cyc(ctc_ff, stc_ff, PH_EXTRA) - 1'b1;
          end else begin
            bit_ff <= bit_ff - 4'h1;
            cnt_ff <= step_cyc(ctc_ff, stc_ff) - 1'b1;
          end
        end
        ST_EXTRA: begin
          if (cnt_ff == '0) begin
            st_ff <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  // Range flags are frozen when the sample phase ends.
  always_ff @(posedge clock) begin
    if (srst) begin
      below_ff <= 1'b0;
      above_ff <= 1'b0;
    end else if (st_ff == ST_SAMPLE && cnt_ff == '0) begin
      below_ff <= input_below_ground;
      above_ff <= input_above_ref;
    end
  end

  // Result transfer at the end of the extra phase, with range clamping.
  always_ff @(posedge clock) begin
    if (srst) begin
      result_ff <= '0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      if (st_ff == ST_EXTRA && cnt_ff == '0 && !pwr_off) begin
        valid_ff <= 1'b1;
        if (below_ff) begin
          result_ff <= RES_W'(`RESULT_ZERO);
        end else if (above_ff) begin
          result_ff <= RES_W'(`RESULT_FULL);
        end else begin
          result_ff <= link.code;
        end
      end
    end
  end

  // Power state and the reserved-setting flag.
  always_ff @(posedge clock) begin
    if (srst) begin
      analog_on_ff <= 1'b0;
      reserved_ff <= 1'b0;
    end else begin
      analog_on_ff <= !pwr_off;
      if (conv_start && st_ff == ST_IDLE) begin
        reserved_ff <= (ctc_in == `CTC_RESERVED);
      end
    end
  end

  sar_register #(.RES_W(RES_W)) u_sar (
    .clock(clock),
    .srst(srst),
    .link(link)
  );

  logic [CNT_W-1:0] len_ff;
  logic [12:0] total_ff;
  logic [12:0] exp_total;
  logic [3:0] dec_ff;
  assign exp_total = 13'(phase_cyc(ctc_ff, stc_ff, PH_SAMPLE))
    + 13'(phase_cyc(ctc_ff, stc_ff, PH_COMPARE))
    + 13'(phase_cyc(ctc_ff, stc_ff, PH_EXTRA));
  always_ff @(posedge clock) begin
    if (srst) begin
      len_ff <= '0;
      total_ff <= '0;
      dec_ff <= 4'h0;
    end else begin
      len_ff <= (accept || phase_end) ? '0 : len_ff + 1'b1;
      total_ff <= accept ? 13'h0000 : total_ff + 13'h0001;
      dec_ff <= accept ? 4'h0 : dec_ff + 4'(link.decide);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  start_sample_a: assert property (accept |=> sample_switch && busy)
    else $error("Start did not open the sample phase.");
  sample_len_a: assert property (st_ff == ST_SAMPLE && phase_end && !pwr_off
    |-> len_ff + 1'b1 == phase_cyc(ctc_ff, stc_ff, PH_SAMPLE))
    else $error("Sample phase length wrong.");
  compare_len_a: assert property (st_ff == ST_COMPARE && phase_end
    && !pwr_off |-> len_ff + 1'b1 == phase_cyc(ctc_ff, stc_ff, PH_COMPARE))
    else $error("Comparison phase length wrong.");
  extra_len_a: assert property (st_ff == ST_EXTRA && phase_end && !pwr_off
    |-> len_ff + 1'b1 == phase_cyc(ctc_ff, stc_ff, PH_EXTRA))
    else $error("Extra phase length wrong.");
  total_time_a: assert property (result_valid |-> total_ff == exp_total
    && total_ff >= 13'(`TOTAL_MIN_HALVES / `HALVES_PER_CLK))
    else $error("Total conversion time wrong.");
  bit_steps_a: assert property (result_valid |-> dec_ff == 4'(RES_W))
    else $error("Wrong number of comparison steps.");
  sample_hold_a: assert property (st_ff == ST_COMPARE || st_ff == ST_EXTRA
    |=> $stable(below_ff) && $stable(above_ff))
    else $error("Held range state changed after sampling.");
  clamp_low_a: assert property (result_valid && below_ff
    |-> result == RES_W'(`RESULT_ZERO))
    else $error("Below-ground input not clamped to zero.");
  clamp_high_a: assert property (result_valid && !below_ff && above_ff
    |-> result == RES_W'(`RESULT_FULL))
    else $error("Over-reference input not clamped to full scale.");
  power_off_a: assert property (pwr_off |=> !busy && !analog_enable)
    else $error("Power-off did not stop the converter.");
  reserved_a: assert property (st_ff == ST_IDLE && conv_start
    && ctc_in == `CTC_RESERVED |=> !busy && ctrl_reserved_error)
    else $error("Reserved timing setting started a conversion.");
endmodule : adc_conversion_timing_sequencer

// File: testbench/analog_array_model.sv
// Behavioural sample-and-compare array that faces the sequencer.
module analog_array_model (
  input wire logic clock,
  input wire logic analog_enable,
  input wire logic sample_switch,
  input wire logic [9:0] dac_code,
  input wire logic signed [11:0] level,
  output logic cmp_above,
  output logic input_below_ground,
  output logic input_above_ref
);
  timeunit 1ns;
  timeprecision 100ps;
  logic signed [11:0] held_ff = 12'sh000;
  logic toggle_ff = 1'b0;
  // The capacitors follow the input only while the sample switch is closed.
  always_ff @(posedge clock) begin
    toggle_ff <= ~toggle_ff;
    if (sample_switch && analog_enable) begin
      held_ff <= level;
    end
  end
  // Out-of-range charge wraps here; a powered-off comparator is unstable.
  always_comb begin
    if (analog_enable) begin
      cmp_above = held_ff[9:0] >= dac_code;
    end else begin
      cmp_above = toggle_ff;
    end
  end
  assign input_below_ground = level < 0;
  assign input_above_ref = level > 1023;
endmodule : analog_array_model

// File: testbench/adc_conversion_timing_sequencer_test.sv
// Self-checking bench for the conversion timing sequencer.
module adc_conversion_timing_sequencer_test import adc_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic conv_start = 1'b0;
  logic [15:0] ctrl = 16'h0000;
  logic signed [11:0] level = 12'sh000;
  logic cmp_above, below, above, analog_enable, sample_switch;
  logic busy, result_valid, ctrl_reserved_error;
  logic [9:0] dac_code, result;
  int error_cnt = 0;
  int n_compared = 0;
  int smp[4] = '{120, 140, 200, 400};
  int cmpt[4] = '{240, 280, 280, 280};
  int scale[4] = '{1, 0, 4, 2};
  int ext[4][4] = '{'{28, 16, 52, 44}, '{0, 0, 0, 0},
    '{100, 52, 196, 164}, '{52, 28, 100, 52}};

  adc_conversion_timing_sequencer dut (.clock(clock), .srst(srst),
    .conv_start(conv_start), .converter_control_register(ctrl),
    .cmp_above(cmp_above), .input_below_ground(below),
    .input_above_ref(above), .analog_enable(analog_enable),
    .sample_switch(sample_switch), .dac_code(dac_code), .busy(busy),
    .result(result), .result_valid(result_valid),
    .ctrl_reserved_error(ctrl_reserved_error));

  analog_array_model array (.clock(clock), .analog_enable(analog_enable),
    .sample_switch(sample_switch), .dac_code(dac_code), .level(level),
    .cmp_above(cmp_above), .input_below_ground(below),
    .input_above_ref(above));

  initial begin
    forever #2.5 clock = ~clock;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task results;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task start(input logic [15:0] c);
    @(posedge clock);
    #1 ctrl = c;
    conv_start = 1'b1;
    @(posedge clock);
    #1 conv_start = 1'b0;
  endtask : start

  // Runs one conversion, moves the input after sampling, times the sample phase and the whole conversion.
  task convert(input logic [1:0] ctc, input logic [1:0] stc,
    input logic signed [11:0] lv, input logic [9:0] exp);
    int n, ns, nb, s, c, e;
    s = smp[stc] * scale[ctc] / 2;
    c = cmpt[stc] * scale[ctc] / 2;
    e = ext[ctc][stc] / 2;
    level = lv;
    start({ctc, stc, 12'h000});
    check(16'(dac_code), 16'h0200);
    ctrl = {~ctc, ~stc, 12'h000};
    n = 1;
    ns = 0;
    nb = 0;
    while (result_valid !== 1'b1 && n < 2000) begin
      if (sample_switch === 1'b1) begin
        ns++;
      end else begin
        level = 12'sd1023 - lv;
      end
      if (busy === 1'b1) begin
        nb++;
      end
      @(posedge clock);
      #1 n++;
    end
    check(16'(n), 16'(s + c + e + 1));
    check(16'(ns), 16'(s));
    check(16'(nb), 16'(s + c + e));
    check(16'(result), 16'(exp));
    check(16'(busy), 16'h0000);
  endtask : convert

  task all_timings;
    logic [1:0] ctcs[3];
    ctcs = '{2'b00, 2'b11, 2'b10};
    foreach (ctcs[i]) begin
      for (int stc = 0; stc < 4; stc++) begin
        convert(ctcs[i], 2'(stc), 12'(ctcs[i] * 100 + stc * 211 + 7),
          10'(ctcs[i] * 100 + stc * 211 + 7));
      end
    end
    convert(2'b00, 2'b00, -12'sd5, 10'h000);
    convert(2'b00, 2'b01, 12'sd1500, 10'h3ff);
  endtask : all_timings

  task power_test;
    int nrv;
    ctrl = 16'h0080;
    repeat (2) @(posedge clock);
    #1 check(16'(analog_enable), 16'h0000);
    start(16'h0080);
    check(16'(busy), 16'h0000);
    ctrl = 16'h0000;
    repeat (2) @(posedge clock);
    #1 check(16'(analog_enable), 16'h0001);
    start(16'h0000);
    repeat (20) @(posedge clock);
    #1 ctrl = 16'h0080;
    nrv = 0;
    repeat (300) begin
      @(posedge clock);
      #1 nrv += (result_valid === 1'b1);
    end
    check(16'(busy), 16'h0000);
    check(16'(nrv), 16'h0000);
    ctrl = 16'h0000;
    repeat (2) @(posedge clock);
  endtask : power_test

  task reserved_test;
    start(16'h4000);
    check(16'(busy), 16'h0000);
    check(16'(ctrl_reserved_error), 16'h0001);
    convert(2'b00, 2'b00, 12'sd512, 10'h200);
    check(16'(ctrl_reserved_error), 16'h0000);
  endtask : reserved_test

  initial begin
    repeat (4) @(posedge clock);
    #1 srst = 1'b0;
    check(16'(result), 16'h0000);
    check(16'(busy), 16'h0000);
    all_timings();
    power_test();
    reserved_test();
    results();
  end

  initial begin
    #200000;
    error_cnt++;
    results();
  end
endmodule : adc_conversion_timing_sequencer_test
